// ---- gpm_defines.vh ----
`ifndef GPM_DEFINES_VH
`define GPM_DEFINES_VH
// Register byte addresses on the Avalon-MM slave.
`define GPM_OFF_STRAP      4'h0
`define GPM_OFF_GAME       4'h1
`define GPM_OFF_POLARITY   4'h2
`define GPM_OFF_PARPORT_A  4'h3
`define GPM_OFF_PARPORT_B  4'h4
`define GPM_OFF_PD_TRI_A   4'h5
`define GPM_OFF_PD_TRI_B   4'h6
`define GPM_OFF_IR         4'h7
`define GPM_OFF_STATUS     4'h8
// Field positions.
`define GPM_BIT_GAME_OR_DMA   3
`define GPM_BIT_GAME_MODE     4
`define GPM_BIT_FDC_POL       7
`define GPM_BIT_EXT_POL       6
`define GPM_BIT_PD_POL        4
`define GPM_BIT_IR_OUT        0
`define GPM_BIT_PRTMOD_A0     2
`define GPM_BIT_PRTMOD_A1     3
`define GPM_BIT_PRTMOD_B2     7
// Reset values.
`define GPM_RST_GAME      8'h00
`define GPM_RST_POLARITY  8'h00
`define GPM_RST_PARPORT_A 8'h00
`define GPM_RST_PARPORT_B 8'h00
`define GPM_RST_PD_TRI    8'h00
`define GPM_RST_IR        8'h00
// Parallel-port modes, value of {bit2,bit1,bit0}.
`define GPM_PM_PRINTER   3'h0
`define GPM_PM_EXT_FDD   3'h1
`define GPM_PM_EXT_ADPT  3'h2
`define GPM_PM_EXT_2FDD  3'h3
`define GPM_PM_JOYSTICK  3'h4
`define GPM_PM_EPP       3'h5
`define GPM_PM_ECP       3'h6
`define GPM_PM_ECP_EPP   3'h7
`endif

// ---- gpm_parport_decode.v ----
`timescale 1ns/1ns
`default_nettype none
module gpm_parport_decode
(
  input  wire [2:0] mode,
  output reg        is_printer,
  output reg        is_fdd,
  output reg        is_2fdd,
  output reg        is_adapter,
  output reg        is_extended
);
`include "gpm_defines.vh"
  always @*
  begin
    is_printer  = 1'b0;
    is_fdd      = 1'b0;
    is_2fdd     = 1'b0;
    is_adapter  = 1'b0;
    is_extended = 1'b0;
    case (mode)
      `GPM_PM_PRINTER:  is_printer = 1'b1;
      `GPM_PM_EXT_FDD:  is_fdd = 1'b1;
      `GPM_PM_EXT_2FDD: is_2fdd = 1'b1;
      `GPM_PM_EXT_ADPT:
      begin
        is_adapter  = 1'b1;
        is_extended = 1'b1;
      end
      `GPM_PM_EPP, `GPM_PM_ECP, `GPM_PM_ECP_EPP: is_extended = 1'b1;
      default: is_printer = 1'b0;
    endcase
  end
endmodule // gpm_parport_decode
`default_nettype wire

// ---- gpm_pin_mux.v ----
// Function
// - Select bit set: game mode bit picks adapter or portable, adapter default.
// - Select bit clear: game pins carry DMA A acknowledge in, request out.
// - Adapter mode drives game read strobe and game write strobe.
// - Portable: floppy enable active in extension FDD/2FDD, polarity bit, low default.
// - Portable: extension enable active in adapter/EPP/ECP modes, polarity bit, low default.
// - Active power-down gates internal clock and tri-states selected outputs.
// - Power-down polarity from control bit, high default, undriven means inactive.
// - IR pin is fast receive input or mode-select-0 output per IR register.
// - Parallel pins take one of eight functions from three mode bits.
// - Extension FDD/2FDD: busy pin is open-drain motor-on output.
// - Extension FDD/2FDD: acknowledge pin is open-drain drive-select output.
// - Joystick mode leaves busy and acknowledge pins undriven and ignored.
// - Game-or-DMA select bit loads from strap pin at reset, default low.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_mux
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clk_en,
  // Avalon-MM slave.
  input  wire [3:0] avs_address,
  input  wire       avs_read,
  input  wire       avs_write,
  input  wire [7:0] avs_writedata,
  output reg  [7:0] avs_readdata,
  output wire       avs_waitrequest,
  // Strap sampled during reset.
  input  wire       strap_game_or_dma,
  // Core-side functions.
  input  wire       game_read_req,
  input  wire       game_write_req,
  input  wire       dma_request_channel_a,
  output wire       dma_ack_channel_a,
  input  wire       ext_drive_b_motor_on,
  input  wire       ext_drive_b_select,
  output wire       ext_adapter_irq_in,
  output wire       ext_adapter_dma_req_in,
  output wire       printer_busy,
  output wire       printer_ack_n,
  input  wire       ir_mode_sel0,
  output wire       ir_fast_rx,
  input  wire [15:0] core_out_en,
  output wire [15:0] pin_out_en,
  output wire       chip_clk_enable,
  // Power-down pin: drive flag says whether the board drives it.
  input  wire       power_down_input,
  input  wire       power_down_driven,
  // Game pin 41 (read strobe / floppy enable / DMA ack).
  input  wire       game_pin_a_in,
  output wire       game_pin_a_out,
  output wire       game_pin_a_oe,
  // Game pin 39 (write strobe / extension enable / DMA request).
  output wire       game_pin_b_out,
  output wire       game_pin_b_oe,
  // Parallel busy and acknowledge pins; drive flags model pull-ups.
  input  wire       busy_pin_in,
  input  wire       busy_pin_driven,
  output wire       busy_pin_out,
  output wire       busy_pin_oe,
  input  wire       ack_pin_in,
  input  wire       ack_pin_driven,
  output wire       ack_pin_out,
  output wire       ack_pin_oe,
  // Shared IR pin.
  input  wire       ir_pin_in,
  output wire       ir_pin_out,
  output wire       ir_pin_oe
);
`include "gpm_defines.vh"
  //////////////////////////////////////////////////////////////////////////////
  reg  [7:0] strap_config_reg;
  reg  [7:0] game_config_reg;
  reg  [7:0] portable_polarity_reg;
  reg  [7:0] parport_config_reg_a;
  reg  [7:0] parport_config_reg_b;
  reg  [7:0] power_down_tristate_reg_a;
  reg  [7:0] power_down_tristate_reg_b;
  reg  [7:0] ir_config_reg;
  reg  [7:0] read_next;
  reg        rd_valid_reg;
  wire       game_or_dma_select;
  wire       game_port_mode_select;
  wire [2:0] parport_mode;
  wire       is_printer;
  wire       is_fdd;
  wire       is_2fdd;
  wire       is_adapter;
  wire       is_extended;
  wire       pd_active;
  wire       adapter_mode;
  wire       portable_mode;
  wire       floppy_on;
  wire       ext_on;
  wire       portable_floppy_enable;
  wire       portable_extension_enable;
  wire       busy_level;
  wire       ack_level;

  // A read is held off for one cycle so that the registered read data already
  // stands at the edge where the master sees waitrequest low. Writes finish at
  // once. Nothing finishes while clk_en is low, so no request is silently lost.
  assign avs_waitrequest = (~clk_en & (avs_read | avs_write)) |
                           (avs_read & ~rd_valid_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers. The strap is captured on every clock edge while reset is low, so the
  // level seen during reset becomes the power-on value.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      strap_config_reg          <= {4'h0, strap_game_or_dma, 3'h0};
      game_config_reg           <= `GPM_RST_GAME;
      portable_polarity_reg     <= `GPM_RST_POLARITY;
      parport_config_reg_a      <= `GPM_RST_PARPORT_A;
      parport_config_reg_b      <= `GPM_RST_PARPORT_B;
      power_down_tristate_reg_a <= `GPM_RST_PD_TRI;
      power_down_tristate_reg_b <= `GPM_RST_PD_TRI;
      ir_config_reg             <= `GPM_RST_IR;
      avs_readdata              <= 8'h00;
      rd_valid_reg              <= 1'b0;
    end
    else if (clk_en)
    begin
      if (avs_write)
      begin
        case (avs_address)
          `GPM_OFF_STRAP:     strap_config_reg <= avs_writedata;
          `GPM_OFF_GAME:      game_config_reg <= avs_writedata;
          `GPM_OFF_POLARITY:  portable_polarity_reg <= avs_writedata;
          `GPM_OFF_PARPORT_A: parport_config_reg_a <= avs_writedata;
          `GPM_OFF_PARPORT_B: parport_config_reg_b <= avs_writedata;
          `GPM_OFF_PD_TRI_A:  power_down_tristate_reg_a <= avs_writedata;
          `GPM_OFF_PD_TRI_B:  power_down_tristate_reg_b <= avs_writedata;
          `GPM_OFF_IR:        ir_config_reg <= avs_writedata;
          default:            ir_config_reg <= ir_config_reg;
        endcase
      end
      if (avs_read && !rd_valid_reg)
        avs_readdata <= read_next;
      rd_valid_reg <= avs_read & ~rd_valid_reg;
    end
  end

  always @*
  begin
    case (avs_address)
      `GPM_OFF_STRAP:     read_next = strap_config_reg;
      `GPM_OFF_GAME:      read_next = game_config_reg;
      `GPM_OFF_POLARITY:  read_next = portable_polarity_reg;
      `GPM_OFF_PARPORT_A: read_next = parport_config_reg_a;
      `GPM_OFF_PARPORT_B: read_next = parport_config_reg_b;
      `GPM_OFF_PD_TRI_A:  read_next = power_down_tristate_reg_a;
      `GPM_OFF_PD_TRI_B:  read_next = power_down_tristate_reg_b;
      `GPM_OFF_IR:        read_next = ir_config_reg;
      `GPM_OFF_STATUS:    read_next = {3'h0, pd_active, ext_on, floppy_on, parport_mode[1:0]};
      default:            read_next = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode; everything below is combinational so a write acts at once.
  assign game_or_dma_select    = strap_config_reg[`GPM_BIT_GAME_OR_DMA];
  assign game_port_mode_select = game_config_reg[`GPM_BIT_GAME_MODE];
  assign parport_mode = {parport_config_reg_b[`GPM_BIT_PRTMOD_B2],
                         parport_config_reg_a[`GPM_BIT_PRTMOD_A1],
                         parport_config_reg_a[`GPM_BIT_PRTMOD_A0]};

  gpm_parport_decode u_decode
  (
    .mode        (parport_mode),
    .is_printer  (is_printer),
    .is_fdd      (is_fdd),
    .is_2fdd     (is_2fdd),
    .is_adapter  (is_adapter),
    .is_extended (is_extended)
  );

  // An undriven power-down pin reads as inactive whatever the polarity.
  assign pd_active = power_down_driven &
                     (power_down_input ~^ ~portable_polarity_reg[`GPM_BIT_PD_POL]);
  assign chip_clk_enable = clk_en & ~pd_active;
  assign pin_out_en = pd_active ?
                      core_out_en & ~{power_down_tristate_reg_b, power_down_tristate_reg_a} :
                      core_out_en;

  //////////////////////////////////////////////////////////////////////////////
  // Game port pins.
  assign adapter_mode  = game_or_dma_select & ~game_port_mode_select;
  assign portable_mode = game_or_dma_select &  game_port_mode_select;
  assign floppy_on = is_fdd | is_2fdd;
  assign ext_on    = is_extended;
  // Polarity bit 0 gives the default active-low level.
  assign portable_floppy_enable    = floppy_on ~^ portable_polarity_reg[`GPM_BIT_FDC_POL];
  assign portable_extension_enable = ext_on ~^ portable_polarity_reg[`GPM_BIT_EXT_POL];

  assign game_pin_a_out = adapter_mode  ? game_read_req :
                          portable_mode ? portable_floppy_enable :
                          1'b0;
  assign game_pin_a_oe  = game_or_dma_select;
  assign game_pin_b_out = adapter_mode  ? game_write_req :
                          portable_mode ? portable_extension_enable :
                          dma_request_channel_a;
  assign game_pin_b_oe  = 1'b1;
  // The acknowledge is only honoured while the pin is a DMA input.
  assign dma_ack_channel_a = ~game_or_dma_select & game_pin_a_in;

  //////////////////////////////////////////////////////////////////////////////
  // Parallel busy and acknowledge pins. Open-drain outputs only pull low, so
  // the drive enable is the motor-on or drive-select input, gated by FDD/2FDD mode.
  assign busy_level = busy_pin_driven ? busy_pin_in : 1'b1;
  assign ack_level  = ack_pin_driven  ? ack_pin_in  : 1'b1;
  assign printer_busy  = is_printer ? busy_level : 1'b0;
  assign printer_ack_n = is_printer ? ack_level  : 1'b1;
  assign ext_adapter_irq_in     = is_adapter & busy_level;
  assign ext_adapter_dma_req_in = is_adapter & ack_level;
  assign busy_pin_out = 1'b0;
  assign busy_pin_oe  = floppy_on & ext_drive_b_motor_on;
  assign ack_pin_out  = 1'b0;
  assign ack_pin_oe   = floppy_on & ext_drive_b_select;

  //////////////////////////////////////////////////////////////////////////////
  // Shared IR pin direction comes from the IR configuration register.
  assign ir_pin_oe  = ir_config_reg[`GPM_BIT_IR_OUT];
  assign ir_pin_out = ir_pin_oe & ir_mode_sel0;
  assign ir_fast_rx = ~ir_pin_oe & ir_pin_in;
endmodule // gpm_pin_mux
`default_nettype wire

// ---- gpm_pin_mux_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "gpm_defines.vh"
module gpm_pin_mux_chk
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic [3:0] avs_address,
  input wire logic       avs_write,
  input wire logic [7:0] avs_writedata,
  input wire logic       game_pin_a_in,
  input wire logic       game_pin_a_oe,
  input wire logic       game_pin_b_out,
  input wire logic       dma_request_channel_a,
  input wire logic       dma_ack_channel_a,
  input wire logic       busy_pin_oe,
  input wire logic       busy_pin_out,
  input wire logic       ack_pin_oe,
  input wire logic       ack_pin_out,
  input wire logic       ext_drive_b_motor_on,
  input wire logic       ext_drive_b_select,
  input wire logic       ext_adapter_irq_in,
  input wire logic       ext_adapter_dma_req_in,
  input wire logic       printer_busy,
  input wire logic       printer_ack_n,
  input wire logic       power_down_driven,
  input wire logic       chip_clk_enable,
  input wire logic       ir_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ir_write_s;
    clk_en && avs_write && avs_address == `GPM_OFF_IR;
  endsequence
  ir_dir_follow_a: assert property (ir_write_s |=> ir_pin_oe == $past(avs_writedata[0]))
    else $error("ir pin direction differs from written bit");
  dma_ack_path_a: assert property (dma_ack_channel_a |-> game_pin_a_in && !game_pin_a_oe
    && game_pin_b_out == dma_request_channel_a) else $error("dma channel a pins wrong");
  busy_open_drain_a: assert property (busy_pin_oe |-> !busy_pin_out && ext_drive_b_motor_on
    && !printer_busy && !ext_adapter_irq_in) else $error("busy pin drive wrong");
  ack_open_drain_a: assert property (ack_pin_oe |-> !ack_pin_out && ext_drive_b_select
    && printer_ack_n && !ext_adapter_dma_req_in) else $error("ack pin drive wrong");
  busy_exclusive_a: assert property (printer_busy |-> !busy_pin_oe && !ext_adapter_irq_in)
    else $error("busy functions overlap");
  drq_input_a: assert property (ext_adapter_dma_req_in |-> !ack_pin_oe && printer_ack_n)
    else $error("adapter dma request while ack pin driven");
  pd_undriven_a: assert property (!power_down_driven |-> chip_clk_enable == clk_en)
    else $error("clock gated with power-down undriven");
  pd_gate_cause_a: assert property (clk_en && !chip_clk_enable |-> power_down_driven)
    else $error("clock gated without power-down");
endmodule // gpm_pin_mux_chk
bind gpm_pin_mux gpm_pin_mux_chk gpm_pin_mux_chk_inst (.*);
`default_nettype wire

// ---- gpm_far_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module gpm_far_model
(
  input  wire logic drive_en,
  input  wire logic busy_level,
  input  wire logic ack_level,
  input  wire logic busy_pin_out,
  input  wire logic busy_pin_oe,
  input  wire logic ack_pin_out,
  input  wire logic ack_pin_oe,
  output logic      busy_pin_in,
  output logic      busy_pin_driven,
  output logic      ack_pin_in,
  output logic      ack_pin_driven
);
  // Printer or adapter drives only in its own modes; a released line rises on its pull-up.
  assign busy_pin_driven = drive_en;
  assign ack_pin_driven  = drive_en;
  assign busy_pin_in = busy_pin_oe ? busy_pin_out : (drive_en ? busy_level : 1'b1);
  assign ack_pin_in  = ack_pin_oe ? ack_pin_out : (drive_en ? ack_level : 1'b1);
endmodule // gpm_far_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "gpm_defines.vh"
module tb_top;
  logic        clk, rst_n, clk_en, avs_read, avs_write, strap_game_or_dma, game_read_req;
  logic        game_write_req, dma_request_channel_a, ext_drive_b_motor_on, ext_drive_b_select;
  logic        ir_mode_sel0, power_down_input, power_down_driven, game_pin_a_in, ir_pin_in;
  logic        drive_en, busy_level, ack_level, fdd, ext;
  logic [3:0]  avs_address;
  logic [7:0]  avs_writedata, rdata;
  logic [15:0] core_out_en;
  wire logic [7:0]  avs_readdata;
  wire logic [15:0] pin_out_en;
  wire logic        avs_waitrequest, dma_ack_channel_a, ext_adapter_irq_in, ir_fast_rx;
  wire logic        ext_adapter_dma_req_in, printer_busy, printer_ack_n, chip_clk_enable;
  wire logic        game_pin_a_out, game_pin_a_oe, game_pin_b_out, game_pin_b_oe, ir_pin_out;
  wire logic        busy_pin_in, busy_pin_driven, busy_pin_out, busy_pin_oe, ir_pin_oe;
  wire logic        ack_pin_in, ack_pin_driven, ack_pin_out, ack_pin_oe;
  int n_errors  = 0;
  int tests_run = 0;
  gpm_pin_mux gpm_pin_mux_inst (.*);
  gpm_far_model gpm_far_model_inst (.drive_en(drive_en), .busy_level(busy_level),
    .ack_level(ack_level), .busy_pin_out(busy_pin_out), .busy_pin_oe(busy_pin_oe),
    .ack_pin_out(ack_pin_out), .ack_pin_oe(ack_pin_oe), .busy_pin_in(busy_pin_in),
    .busy_pin_driven(busy_pin_driven), .ack_pin_in(ack_pin_in), .ack_pin_driven(ack_pin_driven));
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Read data is taken at the edge where waitrequest is seen low, and not later.
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    rdata = avs_readdata;
    if (n == 50)
    begin
      n_errors++;
      conclude();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_reset(input logic s);
    rst_n <= 1'b0;
    strap_game_or_dma <= s;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {rst_n, avs_read, avs_write, strap_game_or_dma, game_read_req, game_write_req} = 6'h00;
    {dma_request_channel_a, ext_drive_b_motor_on, ext_drive_b_select, ir_mode_sel0} = 4'h0;
    {power_down_input, power_down_driven, game_pin_a_in, ir_pin_in, drive_en} = 5'h00;
    {busy_level, ack_level, avs_address, avs_writedata} = 14'h0000;
    clk_en = 1'b1;
    core_out_en = 16'hffff;
    do_reset(1'b0);
    xfer(1'b0, `GPM_OFF_STRAP, 8'h00);
    check("strap_low", 8'h00, rdata);
    dma_request_channel_a <= 1'b1;
    game_pin_a_in <= 1'b1;
    @(posedge clk);
    check("dma_pins", 4'h7, {game_pin_a_oe, game_pin_b_oe, game_pin_b_out, dma_ack_channel_a});
    do_reset(1'b1);
    xfer(1'b0, `GPM_OFF_STRAP, 8'h00);
    check("strap_high", 8'h08, rdata);
    xfer(1'b0, `GPM_OFF_GAME, 8'h00);
    check("game_reg", `GPM_RST_GAME, rdata);
    for (int i = 0; i < 4; i++)
    begin
      game_read_req <= i[0];
      game_write_req <= i[1];
      @(posedge clk);
      check("adapter", {1'b1, i[0], i[1], 1'b0},
        {game_pin_a_oe, game_pin_a_out, game_pin_b_out, dma_ack_channel_a});
    end
    xfer(1'b1, `GPM_OFF_GAME, 8'h10);
    ext_drive_b_motor_on <= 1'b1;
    ext_drive_b_select <= 1'b1;
    busy_level <= 1'b1;
    for (int m = 0; m < 8; m++)
    begin
      drive_en <= (m == 0 || m == 2);
      ack_level <= m[1];
      xfer(1'b1, `GPM_OFF_PARPORT_A, {4'h0, m[1:0], 2'b00});
      xfer(1'b1, `GPM_OFF_PARPORT_B, {m[2], 7'h00});
      fdd = (m == 1 || m == 3);
      ext = (m == 2 || m > 4);
      check("portable", {~fdd, ~ext}, {game_pin_a_out, game_pin_b_out});
      check("parport", {fdd, fdd, ~fdd, m == 0, m != 0, m == 2, m == 2}, {busy_pin_oe, ack_pin_oe,
        busy_pin_in, printer_busy, printer_ack_n, ext_adapter_irq_in, ext_adapter_dma_req_in});
    end
    xfer(1'b1, `GPM_OFF_POLARITY, 8'hc0);
    check("polarity", 2'b01, {game_pin_a_out, game_pin_b_out});
    xfer(1'b1, `GPM_OFF_PD_TRI_A, 8'h0f);
    xfer(1'b1, `GPM_OFF_PD_TRI_B, 8'h80);
    power_down_input <= 1'b1;
    @(posedge clk);
    check("pd_undriven", 17'h1ffff, {chip_clk_enable, pin_out_en});
    power_down_driven <= 1'b1;
    @(posedge clk);
    check("pd_high", 17'h07ff0, {chip_clk_enable, pin_out_en});
    xfer(1'b1, `GPM_OFF_POLARITY, 8'h10);
    check("pd_low_idle", 17'h1ffff, {chip_clk_enable, pin_out_en});
    power_down_input <= 1'b0;
    @(posedge clk);
    check("pd_low", 17'h07ff0, {chip_clk_enable, pin_out_en});
    power_down_driven <= 1'b0;
    ir_mode_sel0 <= 1'b1;
    ir_pin_in <= 1'b1;
    xfer(1'b1, `GPM_OFF_IR, 8'h01);
    check("ir_out", 2'b11, {ir_pin_oe, ir_pin_out});
    xfer(1'b1, `GPM_OFF_IR, 8'h00);
    check("ir_in", 2'b01, {ir_pin_oe, ir_fast_rx});
    clk_en <= 1'b0;
    @(posedge clk);
    check("clk_frozen", 2'b00, {chip_clk_enable, avs_waitrequest});
    clk_en <= 1'b1;
    @(posedge clk);
    xfer(1'b0, 4'hf, 8'h00);
    check("unmapped", 8'h00, rdata);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
